// ===== rtl/cbs_pkg.sv
/*
 * Shared types and constants of the bus-cycle sequencer: instruction
 * classes, machine-cycle kinds, address sources and strobe bundles.
 * Assumes one T-state per clock of the system clock.
 */
package cbs_pkg;

    // ------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------
    localparam logic [1:0] CBS_BUS_STATES  = 2'h3;  // T1 T2 T3
    localparam logic [1:0] CBS_IDLE_STATES = 2'h1;  // One idle state
    localparam int         CBS_IDX_W       = 4;

    // ------------------------------------------------------------
    // Instruction classes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CBS_I_CMP_SINGLE = 4'h0,
        CBS_I_CMP_REPEAT = 4'h1,
        CBS_I_COMPLEMENT = 4'h2,
        CBS_I_DEC_ADJUST = 4'h3,
        CBS_I_INT_DIS    = 4'h4,
        CBS_I_DEC_BRANCH = 4'h5,
        CBS_I_INT_ENA    = 4'h6,
        CBS_I_EXCH_REGS  = 4'h7,
        CBS_I_EXCH_ALT   = 4'h8,
        CBS_I_EXCH_SP_HL = 4'h9,
        CBS_I_EXCH_SP_IX = 4'hA,
        CBS_I_HALT       = 4'hB,
        CBS_I_INT_MODE   = 4'hC,
        CBS_I_INC_REG    = 4'hD,
        CBS_I_INC_MEM    = 4'hE
    } cbs_instr_e;

    // ------------------------------------------------------------
    // Machine-cycle kinds and address sources
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CBS_K_FETCH1 = 3'h0,
        CBS_K_FETCH2 = 3'h1,
        CBS_K_READ   = 3'h2,
        CBS_K_WRITE  = 3'h3,
        CBS_K_IDLE   = 3'h4,
        CBS_K_HALTF  = 3'h5,
        CBS_K_END    = 3'h6
    } cbs_kind_e;

    typedef enum logic [2:0] {
        CBS_A_NONE = 3'h0,
        CBS_A_PC   = 3'h1,
        CBS_A_HL   = 3'h2,
        CBS_A_SP   = 3'h3,
        CBS_A_SP1  = 3'h4
    } cbs_addr_e;

    typedef struct packed {
        cbs_kind_e kind;
        cbs_addr_e addr;
    } cbs_step_s;

    // All active low; data_oe_n low while the data bus is driven
    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic memory_request_n;
        logic io_request_n;
        logic opcode_fetch_cycle_n;
        logic halt_n;
        logic status_n;
        logic data_oe_n;
    } cbs_strobe_s;

    localparam cbs_strobe_s CBS_STROBE_IDLE = 8'hFF;

    // ------------------------------------------------------------
    // Strobe pattern of each machine-cycle kind
    // ------------------------------------------------------------
    function automatic cbs_strobe_s cbs_strobe_of(input cbs_kind_e kind);
        cbs_strobe_s s;
        s = CBS_STROBE_IDLE;
        case (kind)
            CBS_K_FETCH1:
            begin
                s.rd_n = 1'b0; s.memory_request_n = 1'b0;
                s.opcode_fetch_cycle_n = 1'b0; s.status_n = 1'b0;
            end
            CBS_K_FETCH2:
            begin
                s.rd_n = 1'b0; s.memory_request_n = 1'b0;
                s.opcode_fetch_cycle_n = 1'b0;
            end
            CBS_K_READ:
            begin
                s.rd_n = 1'b0; s.memory_request_n = 1'b0;
            end
            CBS_K_WRITE:
            begin
                s.wr_n = 1'b0; s.memory_request_n = 1'b0; s.data_oe_n = 1'b0;
            end
            CBS_K_HALTF:
            begin
                s.rd_n = 1'b0; s.memory_request_n = 1'b0;
                s.opcode_fetch_cycle_n = 1'b0; s.status_n = 1'b0; s.halt_n = 1'b0;
            end
            default: s = CBS_STROBE_IDLE;
        endcase
        return s;
    endfunction

endpackage

// ===== rtl/cbs_cycle_timer.sv
/*
 * Machine-cycle timer: runs the T-states of one machine cycle and drives
 * the registered strobes and address source for it.
 * Assumes a start only when idle or in the last state of a cycle.
 */
`timescale 1ns/1ns
`default_nettype none
module cbs_cycle_timer
    import cbs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Cycle request
    input  wire logic        start,
    input  wire cbs_step_s   step,
    // Cycle state
    output logic             active,
    output logic             last,
    output cbs_strobe_s      strobe,
    output cbs_addr_e        addr_sel
);

    logic [1:0]  cnt_reg;
    logic        active_reg;
    cbs_strobe_s strobe_reg;
    cbs_addr_e   addr_reg;

    assign active   = active_reg;
    assign last     = active_reg && (cnt_reg == 2'h0);
    assign strobe   = strobe_reg;
    assign addr_sel = addr_reg;

    // ------------------------------------------------------------
    // State counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg    <= 2'h0;
            active_reg <= 1'b0;
        end
        else if (start)
        begin
            cnt_reg    <= (step.kind == CBS_K_IDLE) ? CBS_IDLE_STATES - 2'h1
                                                    : CBS_BUS_STATES - 2'h1;
            active_reg <= 1'b1;
        end
        else if (last)
            active_reg <= 1'b0;
        else if (active_reg)
            cnt_reg <= cnt_reg - 2'h1;
    end

    // ------------------------------------------------------------
    // Strobes and address, inactive whenever no cycle runs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strobe_reg <= CBS_STROBE_IDLE;
            addr_reg   <= CBS_A_NONE;
        end
        else if (start)
        begin
            strobe_reg <= cbs_strobe_of(step.kind);
            addr_reg   <= step.addr;
        end
        else if (last)
        begin
            strobe_reg <= CBS_STROBE_IDLE;
            addr_reg   <= CBS_A_NONE;
        end
    end

endmodule
`default_nettype wire

// ===== rtl/cbs_sequencer.sv
/*
 * Bus-cycle sequencer: turns each accepted instruction class into its
 * ordered machine cycles, holds halt mode and gates bus grants and
 * interrupt sampling.
 * Assumes the core presents the branch conditions with the instruction
 * and pulls HALT_EXIT to leave halt mode.
 */
// Summary of operation
// - Each instruction opens with a three-state fetch; second fetch keeps status high.
// - Compare-block: two fetches, read at HL, then five or three idle states.
// - Decrement-branch: fetch, idle, operand read, two more idles if B nonzero.
// - After the marked decrement-branch idle, bus requests are ignored until done.
// - Interrupt requests are not sampled during the interrupt-enable instruction.
// - After halt fetch, repeat fetch cycles with halt low until halt exits.
// - Stack exchange: reads SP, SP+1, idle, writes SP+1 then SP.
`timescale 1ns/1ns
`default_nettype none
module cbs_sequencer
    import cbs_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RSTN,
    // Instruction request
    input  wire logic        INSTR_VALID,
    output logic             INSTR_READY,
    input  wire cbs_instr_e  INSTR_CODE,
    input  wire logic        COUNT_NONZERO,
    input  wire logic        MATCH_FOUND,
    input  wire logic        B_NONZERO,
    // Halt and interrupt
    input  wire logic        HALT_EXIT,
    output logic             HALTED,
    output logic             IRQ_SAMPLE_EN,
    // Bus release
    input  wire logic        BUS_REQ,
    output logic             BUS_ACK,
    // System bus
    output cbs_strobe_s      BUS_STROBE,
    output cbs_addr_e        ADDR_SEL
);

    typedef enum logic [2:0] {
        CBS_S_WAIT = 3'b001,
        CBS_S_RUN  = 3'b010,
        CBS_S_HALT = 3'b100
    } cbs_state_e;

    cbs_state_e           state_reg;
    cbs_state_e           state_next;
    cbs_instr_e           instr_reg;
    logic [CBS_IDX_W-1:0] idx_reg;
    logic                 cond_reg;
    logic                 block_reg;
    logic                 ack_reg;
    logic                 t_active;
    logic                 t_last;
    logic                 boundary;
    logic                 grant_now;
    logic                 issue;
    logic                 t_start;
    cbs_step_s            cur_step;
    cbs_step_s            t_step;

    // ------------------------------------------------------------
    // Machine-cycle list per instruction class
    // ------------------------------------------------------------
    function automatic cbs_step_s step_of(input cbs_instr_e instr,
                                          input logic [CBS_IDX_W-1:0] idx,
                                          input logic cond);
        cbs_step_s s;
        s = '{kind: CBS_K_END, addr: CBS_A_NONE};
        if (idx == 4'h0)
            s = '{kind: CBS_K_FETCH1, addr: CBS_A_PC};
        else
            case (instr)
                CBS_I_CMP_SINGLE, CBS_I_CMP_REPEAT:
                    if (idx == 4'h1)
                        s = '{kind: CBS_K_FETCH2, addr: CBS_A_PC};
                    else if (idx == 4'h2)
                        s = '{kind: CBS_K_READ, addr: CBS_A_HL};
                    // Only the repeat form stretches to five idles
                    else if (idx <= ((cond && instr == CBS_I_CMP_REPEAT) ? 4'h7 : 4'h5))
                        s = '{kind: CBS_K_IDLE, addr: CBS_A_NONE};
                CBS_I_DEC_ADJUST, CBS_I_EXCH_ALT, CBS_I_INC_REG:
                    if (idx == 4'h1)
                        s = '{kind: CBS_K_IDLE, addr: CBS_A_NONE};
                CBS_I_INT_MODE:
                    if (idx == 4'h1)
                        s = '{kind: CBS_K_FETCH2, addr: CBS_A_PC};
                CBS_I_DEC_BRANCH:
                    if (idx == 4'h1)
                        s = '{kind: CBS_K_IDLE, addr: CBS_A_NONE};
                    else if (idx == 4'h2)
                        s = '{kind: CBS_K_READ, addr: CBS_A_PC};
                    else if (cond && idx <= 4'h4)
                        s = '{kind: CBS_K_IDLE, addr: CBS_A_NONE};
                CBS_I_EXCH_SP_HL, CBS_I_EXCH_SP_IX:
                begin
                    logic [CBS_IDX_W-1:0] k;
                    k = (instr == CBS_I_EXCH_SP_IX) ? idx - 4'h1 : idx;
                    if (instr == CBS_I_EXCH_SP_IX && idx == 4'h1)
                        s = '{kind: CBS_K_FETCH2, addr: CBS_A_PC};
                    else
                        case (k)
                            4'h1:    s = '{kind: CBS_K_READ,  addr: CBS_A_SP};
                            4'h2:    s = '{kind: CBS_K_READ,  addr: CBS_A_SP1};
                            4'h3:    s = '{kind: CBS_K_IDLE,  addr: CBS_A_NONE};
                            4'h4:    s = '{kind: CBS_K_WRITE, addr: CBS_A_SP1};
                            4'h5:    s = '{kind: CBS_K_WRITE, addr: CBS_A_SP};
                            default: s = '{kind: CBS_K_END,   addr: CBS_A_NONE};
                        endcase
                end
                CBS_I_INC_MEM:
                    case (idx)
                        4'h1:    s = '{kind: CBS_K_READ,  addr: CBS_A_HL};
                        4'h2:    s = '{kind: CBS_K_IDLE,  addr: CBS_A_NONE};
                        4'h3:    s = '{kind: CBS_K_WRITE, addr: CBS_A_HL};
                        default: s = '{kind: CBS_K_END,   addr: CBS_A_NONE};
                    endcase
                default: s = '{kind: CBS_K_END, addr: CBS_A_NONE};
            endcase
        return s;
    endfunction

    // ------------------------------------------------------------
    // Issue control
    // ------------------------------------------------------------
    // Grants are only taken at machine-cycle boundaries, never mid-cycle
    assign boundary  = !t_active || t_last;
    assign grant_now = boundary && BUS_REQ && !ack_reg && !block_reg;
    assign issue     = boundary && !ack_reg && !grant_now;
    assign cur_step  = step_of(instr_reg, idx_reg, cond_reg);

    always_comb
    begin
        state_next = state_reg;
        t_start    = 1'b0;
        t_step     = '{kind: CBS_K_END, addr: CBS_A_NONE};
        case (state_reg)
            CBS_S_WAIT:
                if (issue && INSTR_VALID)
                    state_next = CBS_S_RUN;
            CBS_S_RUN:
                if (issue)
                begin
                    if (cur_step.kind != CBS_K_END)
                    begin
                        t_start = 1'b1;
                        t_step  = cur_step;
                    end
                    else
                        state_next = (instr_reg == CBS_I_HALT) ? CBS_S_HALT : CBS_S_WAIT;
                end
            CBS_S_HALT:
                if (issue)
                begin
                    if (HALT_EXIT)
                        state_next = CBS_S_WAIT;
                    else
                    begin
                        t_start = 1'b1;
                        t_step  = '{kind: CBS_K_HALTF, addr: CBS_A_PC};
                    end
                end
            default: state_next = CBS_S_WAIT;
        endcase
    end

    assign INSTR_READY   = (state_reg == CBS_S_WAIT) && issue;
    assign HALTED        = (state_reg == CBS_S_HALT);
    assign BUS_ACK       = ack_reg;
    assign IRQ_SAMPLE_EN = !((state_reg == CBS_S_RUN) && (instr_reg == CBS_I_INT_ENA));

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            state_reg <= CBS_S_WAIT;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            instr_reg <= CBS_I_COMPLEMENT;
            idx_reg   <= 4'h0;
            cond_reg  <= 1'b0;
        end
        else if (INSTR_READY && INSTR_VALID)
        begin
            instr_reg <= INSTR_CODE;
            idx_reg   <= 4'h0;
            // Conditions are frozen for the whole instruction
            cond_reg  <= (INSTR_CODE == CBS_I_DEC_BRANCH) ? B_NONZERO
                                                          : (COUNT_NONZERO && !MATCH_FOUND);
        end
        else if (t_start && state_reg == CBS_S_RUN)
            idx_reg <= idx_reg + 4'h1;
    end

    // ------------------------------------------------------------
    // Bus release gating
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            block_reg <= 1'b0;
        else if (t_start && instr_reg == CBS_I_DEC_BRANCH && idx_reg == 4'h1)
            block_reg <= 1'b1;
        else if (state_reg == CBS_S_RUN && issue && cur_step.kind == CBS_K_END)
            block_reg <= 1'b0;
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            ack_reg <= 1'b0;
        else if (grant_now)
            ack_reg <= 1'b1;
        else if (!BUS_REQ)
            ack_reg <= 1'b0;
    end

    cbs_cycle_timer u_timer (
        .clk      (CLK),
        .rst_n    (RSTN),
        .start    (t_start),
        .step     (t_step),
        .active   (t_active),
        .last     (t_last),
        .strobe   (BUS_STROBE),
        .addr_sel (ADDR_SEL)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Instruction length counter, voided by any bus grant inside it
    logic [7:0] len_reg;
    logic       stalled_reg;
    logic       fin;
    assign fin = state_reg == CBS_S_RUN && issue && cur_step.kind == CBS_K_END;

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            len_reg     <= 8'h00;
            stalled_reg <= 1'b0;
        end
        else if (state_reg != CBS_S_RUN)
        begin
            len_reg     <= 8'h00;
            stalled_reg <= 1'b0;
        end
        else
        begin
            len_reg     <= len_reg + 8'h01;
            stalled_reg <= stalled_reg || ack_reg || grant_now;
        end
    end

    chk_fetch_shape: assert property (@(posedge CLK) disable iff (!RSTN)
        $fell(BUS_STROBE.opcode_fetch_cycle_n) |->
            (!BUS_STROBE.rd_n && !BUS_STROBE.memory_request_n && BUS_STROBE.wr_n
             && BUS_STROBE.io_request_n)[*3])
        else $error("fetch strobes wrong");
    chk_cmp_length: assert property (@(posedge CLK) disable iff (!RSTN)
        fin && !stalled_reg && (instr_reg == CBS_I_CMP_SINGLE || instr_reg == CBS_I_CMP_REPEAT)
            |-> len_reg == (cond_reg && instr_reg == CBS_I_CMP_REPEAT ? 8'd14 : 8'd12))
        else $error("compare-block length wrong");
    chk_branch_length: assert property (@(posedge CLK) disable iff (!RSTN)
        fin && !stalled_reg && instr_reg == CBS_I_DEC_BRANCH
            |-> len_reg == (cond_reg ? 8'd9 : 8'd7))
        else $error("decrement-branch length wrong");
    chk_grant_block: assert property (@(posedge CLK) disable iff (!RSTN)
        block_reg |=> !$rose(BUS_ACK))
        else $error("bus granted while blocked");
    chk_irq_masked: assert property (@(posedge CLK) disable iff (!RSTN)
        INSTR_READY && INSTR_VALID && INSTR_CODE == CBS_I_INT_ENA
            |=> (!IRQ_SAMPLE_EN)[*4])
        else $error("interrupt sampled during enable");
    chk_halt_cycle: assert property (@(posedge CLK) disable iff (!RSTN)
        !BUS_STROBE.halt_n |-> !BUS_STROBE.opcode_fetch_cycle_n && !BUS_STROBE.status_n
            && !BUS_STROBE.rd_n && HALTED)
        else $error("halt cycle strobes wrong");
    chk_stack_write: assert property (@(posedge CLK) disable iff (!RSTN)
        $fell(BUS_STROBE.wr_n) && ADDR_SEL == CBS_A_SP1 |->
            (!BUS_STROBE.wr_n && BUS_STROBE.rd_n && !BUS_STROBE.memory_request_n)[*3]
            ##1 (!BUS_STROBE.wr_n && ADDR_SEL == CBS_A_SP))
        else $error("stack write order wrong");
    chk_idle_float: assert property (@(posedge CLK) disable iff (!RSTN)
        BUS_STROBE.rd_n && BUS_STROBE.wr_n |-> BUS_STROBE == CBS_STROBE_IDLE)
        else $error("idle state not floated");

endmodule
`default_nettype wire

// ===== tb/cbs_bus_partner.sv
/*
 * Far-side model: memory on the system bus plus one bus
 * requester; counts the read and write machine cycles it serves.
 * Assumes three-state bus cycles and strobes high when idle.
 */
`timescale 1ns/1ns
`default_nettype none
module cbs_bus_partner
    import cbs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // System bus
    input  wire cbs_strobe_s strobe,
    // Requester
    input  wire logic        req_cmd,
    output logic             bus_req,
    // Served cycles
    output var int           rd_cnt,
    output var int           wr_cnt
);
    logic [1:0] phase_reg;

    // ------------------------------------------------------------
    // Requester and cycle counting
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            bus_req <= 1'b0;
        else
            bus_req <= req_cmd;
    end

    // Phase count splits back-to-back cycles with equal strobes
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_reg <= 2'h0;
            rd_cnt    <= 0;
            wr_cnt    <= 0;
        end
        else if (strobe.memory_request_n)
            phase_reg <= 2'h0;
        else
        begin
            phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
            if (phase_reg == 2'h0 && !strobe.rd_n)
                rd_cnt <= rd_cnt + 1;
            if (phase_reg == 2'h0 && !strobe.wr_n)
                wr_cnt <= wr_cnt + 1;
        end
    end
endmodule
`default_nettype wire

// ===== tb/cbs_sequencer_tb_top.sv
/*
 * Self-checking bench of the bus-cycle sequencer: compares strobes and
 * address source clock by clock for each instruction class.
 * Assumes package encodings and strobes one clock after the accept.
 */
`timescale 1ns/1ns
`default_nettype none
module cbs_sequencer_tb_top
    import cbs_pkg::*;
;
    logic        CLK, RSTN, INSTR_VALID, INSTR_READY, COUNT_NONZERO;
    logic        MATCH_FOUND, B_NONZERO, HALT_EXIT, HALTED, IRQ_SAMPLE_EN;
    logic        BUS_REQ, BUS_ACK, REQ_CMD;
    cbs_instr_e  INSTR_CODE;
    cbs_strobe_s BUS_STROBE;
    cbs_addr_e   ADDR_SEL;
    int          rd_cnt, wr_cnt, mismatches, num_checks, cycles;

    cbs_sequencer dut (.CLK(CLK), .RSTN(RSTN), .INSTR_VALID(INSTR_VALID),
        .INSTR_READY(INSTR_READY), .INSTR_CODE(INSTR_CODE),
        .COUNT_NONZERO(COUNT_NONZERO), .MATCH_FOUND(MATCH_FOUND),
        .B_NONZERO(B_NONZERO), .HALT_EXIT(HALT_EXIT), .HALTED(HALTED),
        .IRQ_SAMPLE_EN(IRQ_SAMPLE_EN), .BUS_REQ(BUS_REQ), .BUS_ACK(BUS_ACK),
        .BUS_STROBE(BUS_STROBE), .ADDR_SEL(ADDR_SEL));

    cbs_bus_partner far_side (.clk(CLK), .rst_n(RSTN), .strobe(BUS_STROBE),
        .req_cmd(REQ_CMD), .bus_req(BUS_REQ), .rd_cnt(rd_cnt), .wr_cnt(wr_cnt));

    always #2 CLK = ~CLK;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tick;
        @(posedge CLK);
        #1;
    endtask

    task automatic cmp_bit(input string name, input logic e, input logic g);
        num_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %b seen %b", name, e, g);
        end
    endtask

    task automatic cmp_strobe(input string name, input cbs_strobe_s e, input cbs_strobe_s g);
        num_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic cmp_addr(input string name, input cbs_addr_e e, input cbs_addr_e g);
        num_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic wait_ack(input logic v);
        int w;
        w = 0;
        while (BUS_ACK !== v && w < 10)
        begin
            tick;
            w++;
        end
    endtask

    // Step letters: F/f fetch, p/h/s/t read, H/S/T write, z halt, else idle
    task automatic exp_of(input byte c, output cbs_strobe_s s, output cbs_addr_e a,
                          output int n);
        logic [10:0] v;
        n = 3;
        case (c)
            "F": v = {8'h55, CBS_A_PC};
            "f": v = {8'h57, CBS_A_PC};
            "p": v = {8'h5F, CBS_A_PC};
            "h": v = {8'h5F, CBS_A_HL};
            "s": v = {8'h5F, CBS_A_SP};
            "t": v = {8'h5F, CBS_A_SP1};
            "H": v = {8'h9E, CBS_A_HL};
            "S": v = {8'h9E, CBS_A_SP};
            "T": v = {8'h9E, CBS_A_SP1};
            "z": v = {8'h51, CBS_A_PC};
            default:
            begin
                v = {8'hFF, CBS_A_NONE};
                n = 1;
            end
        endcase
        s = v[10:3];
        a = cbs_addr_e'(v[2:0]);
    endtask

    // req_at >= 0 raises a bus request at that clock; 99 skips the tail
    task automatic run_instr(input cbs_instr_e code, input logic cnz, input logic mf,
                             input logic bnz, input string spec, input int req_at);
        cbs_strobe_s s;
        cbs_addr_e   a;
        int          n;
        int          w;
        int          k;
        INSTR_CODE = code;
        COUNT_NONZERO = cnz;
        MATCH_FOUND = mf;
        B_NONZERO = bnz;
        INSTR_VALID = 1'b1;
        w = 0;
        while (INSTR_READY !== 1'b1 && w < 50)
        begin
            tick;
            w++;
        end
        tick;
        INSTR_VALID = 1'b0;
        // Accepting edge passed; timer starts on the next one
        cmp_strobe("lead", 8'hFF, BUS_STROBE);
        k = 0;
        for (int i = 0; i < spec.len(); i++)
        begin
            exp_of(spec[i], s, a, n);
            repeat (n)
            begin
                tick;
                if (k == req_at)
                    REQ_CMD = 1'b1;
                cmp_strobe("strobe", s, BUS_STROBE);
                if (s !== 8'hFF)
                    cmp_addr("addr", a, ADDR_SEL);
                cmp_bit("irq_sample", code != CBS_I_INT_ENA, IRQ_SAMPLE_EN);
                if (req_at >= 0 && k > req_at)
                    cmp_bit("grant_blocked", 1'b0, BUS_ACK);
                k++;
            end
        end
        if (req_at == -1)
        begin
            tick;
            cmp_strobe("tail", 8'hFF, BUS_STROBE);
            cmp_bit("ready_tail", 1'b1, INSTR_READY);
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_short;
        cbs_instr_e codes [8] = '{CBS_I_COMPLEMENT, CBS_I_DEC_ADJUST, CBS_I_INT_DIS,
            CBS_I_INT_ENA, CBS_I_EXCH_REGS, CBS_I_EXCH_ALT, CBS_I_INT_MODE, CBS_I_INC_REG};
        string specs [8] = '{"F", "Fi", "F", "F", "F", "Fi", "Ff", "Fi"};
        for (int i = 0; i < 8; i++)
            run_instr(codes[i], 1'b0, 1'b0, 1'b0, specs[i], -1);
    endtask

    task automatic test_memory;
        run_instr(CBS_I_CMP_SINGLE, 1'b1, 1'b0, 1'b0, "Ffhiii", -1);
        run_instr(CBS_I_CMP_REPEAT, 1'b1, 1'b0, 1'b0, "Ffhiiiii", -1);
        run_instr(CBS_I_CMP_REPEAT, 1'b1, 1'b1, 1'b0, "Ffhiii", -1);
        run_instr(CBS_I_CMP_REPEAT, 1'b0, 1'b0, 1'b0, "Ffhiii", -1);
        run_instr(CBS_I_DEC_BRANCH, 1'b0, 1'b0, 1'b0, "Fip", -1);
        run_instr(CBS_I_INC_MEM, 1'b0, 1'b0, 1'b0, "FhiH", -1);
        run_instr(CBS_I_EXCH_SP_IX, 1'b0, 1'b0, 1'b0, "FfstiTS", -1);
    endtask

    task automatic test_exchange;
        int r0;
        int w0;
        r0 = rd_cnt;
        w0 = wr_cnt;
        run_instr(CBS_I_EXCH_SP_HL, 1'b0, 1'b0, 1'b0, "FstiTS", -1);
        cmp_bit("reads_served", rd_cnt == r0 + 3, 1'b1);
        cmp_bit("writes_served", wr_cnt == w0 + 2, 1'b1);
    endtask

    task automatic test_bus_release;
        REQ_CMD = 1'b1;
        wait_ack(1'b1);
        cmp_bit("ack_free", 1'b1, BUS_ACK);
        cmp_bit("ready_granted", 1'b0, INSTR_READY);
        cmp_strobe("granted", 8'hFF, BUS_STROBE);
        REQ_CMD = 1'b0;
        wait_ack(1'b0);
        cmp_bit("ack_drop", 1'b0, BUS_ACK);
        tick;
        run_instr(CBS_I_DEC_BRANCH, 1'b0, 1'b0, 1'b1, "Fipii", 4);
        wait_ack(1'b1);
        cmp_bit("ack_after", 1'b1, BUS_ACK);
        REQ_CMD = 1'b0;
        wait_ack(1'b0);
        tick;
    endtask

    task automatic test_halt;
        int w;
        // One all-high clock while the sequencer enters halt mode
        run_instr(CBS_I_HALT, 1'b0, 1'b0, 1'b0, "Fizz", 99);
        cmp_bit("halted", 1'b1, HALTED);
        cmp_bit("ready_halted", 1'b0, INSTR_READY);
        HALT_EXIT = 1'b1;
        w = 0;
        while (HALTED !== 1'b0 && w < 10)
        begin
            tick;
            w++;
        end
        HALT_EXIT = 1'b0;
        cmp_bit("halt_left", 1'b0, HALTED);
        tick;
        cmp_strobe("after_halt", 8'hFF, BUS_STROBE);
        tick;
    endtask

    task automatic print_verdict;
        if (mismatches == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            print_verdict;
        end
    end

    initial
    begin
        CLK = 1'b0;
        RSTN = 1'b0;
        INSTR_VALID = 1'b0;
        INSTR_CODE = CBS_I_COMPLEMENT;
        COUNT_NONZERO = 1'b0;
        MATCH_FOUND = 1'b0;
        B_NONZERO = 1'b0;
        HALT_EXIT = 1'b0;
        REQ_CMD = 1'b0;
        repeat (10) @(posedge CLK);
        #1;
        cmp_strobe("reset", 8'hFF, BUS_STROBE);
        RSTN = 1'b1;
        tick;
        test_short;
        test_memory;
        test_exchange;
        test_bus_release;
        test_halt;
        print_verdict;
    end
endmodule
`default_nettype wire
